/* File: pkg/rcout_pkg.sv */
// shared constants, types and helpers for the reference clock output block
package rcout_pkg;

  // ****************************************
  // register map (byte offsets on the bus)
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SOURCE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_DUTY_LSB = 3;
  localparam int CTL_DIV_LSB = 0;
  localparam int SRC_SEL_LSB = 0;
  localparam logic [1:0] DUTY_RESET = 2'h2;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [3:0] SRC_RESET = 4'h0;

  // ****************************************
  // source codes
  // ****************************************
  localparam int NUM_SOURCES = 11;
  localparam logic [3:0] SRC_LAST_VALID = 4'ha;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic enable;
    logic [1:0] duty;
    logic [2:0] div;
  } rcout_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_RUN
  } rcout_state_t;

  // period of the divided clock counted in source half-periods
  function automatic logic [8:0] rcout_period_halves(input logic [2:0] div);
    rcout_period_halves = 9'h002 << div;
  endfunction

  // high time in source half-periods: duty quarters of the period
  function automatic logic [8:0] rcout_high_halves(input logic [2:0] div,
                                                   input logic [1:0] duty);
    logic [8:0] quarter;
    quarter = rcout_period_halves(div) >> 2;
    rcout_high_halves = 9'({7'h00, duty} * quarter);
  endfunction

endpackage

/* File: src/rcout_src_sel.sv */
// base clock selection and sampled edge detection
module rcout_src_sel #(
  parameter int NUM_SRC = rcout_pkg::NUM_SOURCES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [NUM_SRC-1:0] src_levels,
  input wire logic [3:0] sel,
  output logic level,
  output logic rise,
  output logic fall
);

  logic picked;
  logic next_level;
  logic next_rise;
  logic next_fall;

  // ****************************************
  // selection
  // ****************************************
  always_comb begin
    // reserved codes select a quiet low level, so no clock ever arrives
    if (sel <= rcout_pkg::SRC_LAST_VALID) begin
      picked = src_levels[sel];
    end else begin
      picked = 1'b0;
    end
    next_level = picked;
    next_rise = picked & ~level;
    next_fall = ~picked & level;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (ce) begin
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

endmodule

/* File: src/rcout_phase_cnt.sv */
// phase counter of the divided clock, counted in source half-periods
module rcout_phase_cnt #(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic clear,
  input wire logic advance,
  input wire logic [CNT_W:0] period,
  output logic [CNT_W-1:0] count
);

  logic [CNT_W-1:0] next_count;
  logic [CNT_W:0] bumped;

  always_comb begin
    bumped = {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (advance) begin
      if (bumped >= period) begin
        next_count = '0;
      end else begin
        next_count = bumped[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count <= '0;
    end else if (ce) begin
      count <= next_count;
    end
  end

endmodule

/* File: src/rcout_top.sv */
// reference clock output generator with its avalon-mm register slave
//
// Summary of operation
// - the generated clock is driven on the reference clock output pin while enabled.
// - setting the enable starts the output cleanly on a source rising edge, never a runt.
// - clearing the enable stops the output at once, mid-period if need be.
// - divider and duty may change while enabled at the risk of glitches; software should not.
// - the divider field divides the base clock by two to the power of its value, 1 to 128.
// - the duty field gives 75, 50, 25 or 0 percent high time for codes 11, 10, 01, 00.
// - duty applies only when dividing by two or more; undivided the source passes as is.
// - the upper duty bit resets to one so that the default duty is 50 percent.
// - the output holds its level while the device sleeps, unless the enable is cleared, which still drives it low at once.
// - the four-bit source field picks one of eleven base clocks, codes 0000 to 1010.
// - source codes 1011 to 1111 are reserved and select no clock.
// - control holds enable at bit 7, duty at 4..3, divider at 2..0; bits 6..5 read zero.
module rcout_top #(
  parameter int NUM_SRC = rcout_pkg::NUM_SOURCES,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sleep,
  input wire logic [NUM_SRC-1:0] src_levels,
  input wire logic [rcout_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic ref_clock_out_pin
);

  // ****************************************
  // declarations
  // ****************************************
  rcout_pkg::rcout_ctrl_t ctrl;
  rcout_pkg::rcout_ctrl_t next_ctrl;
  logic [3:0] ref_source_select;
  logic [3:0] next_ref_source_select;
  logic [31:0] next_avs_readdata;
  logic next_avs_waitrequest;

  rcout_pkg::rcout_state_t state;
  rcout_pkg::rcout_state_t next_state;
  logic next_ref_clock_out_pin;

  logic src_level;
  logic src_rise;
  logic src_fall;
  logic cnt_clear;
  logic cnt_advance;
  logic [CNT_W-1:0] phase;
  logic [CNT_W:0] period;
  logic [CNT_W:0] high_time;
  logic [CNT_W:0] phase_next;
  logic access;
  logic [7:0] ctl_byte;
  logic [7:0] src_byte;
  logic [7:0] status_byte;

  // ****************************************
  // register slave
  // ****************************************
  // every access is answered one edge after it is seen: waitrequest idles
  // high and drops for exactly one cycle, which keeps the slave trivial and
  // the read data straight from a flip-flop
  assign access = (avs_read | avs_write) & avs_waitrequest;

  always_comb begin
    // unimplemented control bits are packed as zero
    ctl_byte = 8'h00;
    ctl_byte[rcout_pkg::CTL_ENABLE_BIT] = ctrl.enable;
    ctl_byte[rcout_pkg::CTL_DUTY_LSB +: 2] = ctrl.duty;
    ctl_byte[rcout_pkg::CTL_DIV_LSB +: 3] = ctrl.div;
    src_byte = 8'h00;
    src_byte[rcout_pkg::SRC_SEL_LSB +: 4] = ref_source_select;
    status_byte = {5'h00, ref_clock_out_pin, state == rcout_pkg::ST_RUN,
                   state == rcout_pkg::ST_ARM};
  end

  always_comb begin
    next_ctrl = ctrl;
    next_ref_source_select = ref_source_select;
    next_avs_readdata = avs_readdata;
    next_avs_waitrequest = 1'b1;
    if (access) begin
      next_avs_waitrequest = 1'b0;
      next_avs_readdata = 32'h0000_0000;
      if (avs_read) begin
        case (avs_address[rcout_pkg::ADDR_W-1:2])
          rcout_pkg::OFS_CONTROL[rcout_pkg::ADDR_W-1:2]: begin
            next_avs_readdata = {24'h00_0000, ctl_byte};
          end
          rcout_pkg::OFS_SOURCE[rcout_pkg::ADDR_W-1:2]: begin
            next_avs_readdata = {24'h00_0000, src_byte};
          end
          rcout_pkg::OFS_STATUS[rcout_pkg::ADDR_W-1:2]: begin
            next_avs_readdata = {24'h00_0000, status_byte};
          end
          default: begin
            next_avs_readdata = 32'h0000_0000;
          end
        endcase
      end else if (avs_byteenable[0]) begin
        case (avs_address[rcout_pkg::ADDR_W-1:2])
          rcout_pkg::OFS_CONTROL[rcout_pkg::ADDR_W-1:2]: begin
            // bits 6..5 are simply not stored
            next_ctrl.enable = avs_writedata[rcout_pkg::CTL_ENABLE_BIT];
            // accepted even while running; glitches are the user's choice
            next_ctrl.duty = avs_writedata[rcout_pkg::CTL_DUTY_LSB +: 2];
            next_ctrl.div = avs_writedata[rcout_pkg::CTL_DIV_LSB +: 3];
          end
          rcout_pkg::OFS_SOURCE[rcout_pkg::ADDR_W-1:2]: begin
            // reserved codes are stored but select no clock
            next_ref_source_select = avs_writedata[rcout_pkg::SRC_SEL_LSB +: 4];
          end
          default: begin
            next_ctrl = ctrl;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl.enable <= 1'b0;
      ctrl.duty <= rcout_pkg::DUTY_RESET;
      ctrl.div <= rcout_pkg::DIV_RESET;
      ref_source_select <= rcout_pkg::SRC_RESET;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      ctrl <= next_ctrl;
      ref_source_select <= next_ref_source_select;
      avs_readdata <= next_avs_readdata;
      avs_waitrequest <= next_avs_waitrequest;
    end
  end

  // ****************************************
  // base clock selection
  // ****************************************
  // sources arrive as levels sampled on ref_clk, so a source faster than
  // half of ref_clk cannot be reproduced; edges are found by comparison
  rcout_src_sel #(
    .NUM_SRC(NUM_SRC)
  ) i_rcout_src_sel (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .src_levels(src_levels),
    .sel(ref_source_select),
    .level(src_level),
    .rise(src_rise),
    .fall(src_fall)
  );

  // ****************************************
  // divider and duty shaping
  // ****************************************
  // the phase counter steps on both source edges, so one divided period is
  // 2 * 2^div half-periods and a quarter is a whole number of steps from
  // divide-by-two upward
  always_comb begin
    period = rcout_pkg::rcout_period_halves(ctrl.div);
    high_time = rcout_pkg::rcout_high_halves(ctrl.div, ctrl.duty);
  end

  rcout_phase_cnt #(
    .CNT_W(CNT_W)
  ) i_rcout_phase_cnt (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .clear(cnt_clear),
    .advance(cnt_advance),
    .period(period),
    .count(phase)
  );

  // ****************************************
  // start, stop and sleep sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    next_ref_clock_out_pin = ref_clock_out_pin;
    cnt_clear = 1'b0;
    cnt_advance = 1'b0;
    phase_next = {1'b0, phase} + {{CNT_W{1'b0}}, 1'b1};
    if (phase_next >= period) begin
      phase_next = '0;
    end
    if (!ctrl.enable) begin
      // stop at once, low level, fresh period next time
      next_state = rcout_pkg::ST_IDLE;
      next_ref_clock_out_pin = 1'b0;
      cnt_clear = 1'b1;
    end else if (sleep) begin
      // generator frozen: output keeps whatever level it has
      next_state = state;
      next_ref_clock_out_pin = ref_clock_out_pin;
    end else begin
      case (state)
        rcout_pkg::ST_IDLE: begin
          // output stays low until a source rising edge is seen
          next_state = rcout_pkg::ST_ARM;
          next_ref_clock_out_pin = 1'b0;
          cnt_clear = 1'b1;
        end
        rcout_pkg::ST_ARM: begin
          cnt_clear = 1'b1;
          if (src_rise) begin
            // first period begins on a real source edge: no runt pulse
            next_state = rcout_pkg::ST_RUN;
            if (ctrl.div == 3'h0) begin
              next_ref_clock_out_pin = src_level;
            end else begin
              next_ref_clock_out_pin = high_time != '0;
            end
          end
        end
        rcout_pkg::ST_RUN: begin
          if (ctrl.div == 3'h0) begin
            // undivided: the source waveform itself, duty ignored
            cnt_clear = 1'b1;
            next_ref_clock_out_pin = src_level;
          end else if (src_rise | src_fall) begin
            cnt_advance = 1'b1;
            // high for the first duty quarters of every period
            next_ref_clock_out_pin = phase_next < high_time;
          end
        end
        default: begin
          next_state = rcout_pkg::ST_IDLE;
          next_ref_clock_out_pin = 1'b0;
          cnt_clear = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= rcout_pkg::ST_IDLE;
      ref_clock_out_pin <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      ref_clock_out_pin <= next_ref_clock_out_pin;
    end
  end

endmodule

/* File: tb/rcout_chk_assertions.sv */
// concurrent checks on the ports of the reference clock output block
module rcout_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic sleep,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ref_clock_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ******
  // enable shadow, one cycle behind the design
  // ******
  logic ctl_wr;
  logic en_q;
  logic next_en_q;
  assign ctl_wr = avs_write && !avs_waitrequest && avs_address[3:2] == 2'h0 && avs_byteenable[0];
  always_comb begin
    next_en_q = srst ? 1'b0 : (ctl_wr ? avs_writedata[7] : en_q);
  end
  always_ff @(posedge ref_clk) begin
    en_q <= next_en_q;
  end
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  ctl_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[3:2] == 2'h0
    |-> avs_readdata[31:8] == 24'h0 && avs_readdata[6:5] == 2'h0)
    else $error("control unused bits not zero");
  src_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[3:2] == 2'h1
    |-> avs_readdata[31:4] == 28'h0)
    else $error("source unused bits not zero");
  stop_now_a: assert property (ctl_wr && !avs_writedata[7] |=> !ref_clock_out_pin)
    else $error("output not stopped at once");
  off_low_a: assert property (!en_q && !$past(en_q) |-> !ref_clock_out_pin)
    else $error("output high while disabled");
  sleep_hold_a: assert property (sleep && !avs_write |=> $stable(ref_clock_out_pin))
    else $error("output moved during sleep");
endmodule
bind rcout_top rcout_chk i_rcout_chk (.ref_clk(ref_clk), .srst(srst), .sleep(sleep),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ref_clock_out_pin(ref_clock_out_pin));

/* File: tb/rcout_clk_sink.sv */
// consumer of the reference clock: measures high and low times in system cycles
module rcout_clk_sink (
  input wire logic ref_clk,
  input wire logic pin,
  output int hi_len,
  output int lo_len,
  output int falls
);
  timeunit 1ns;
  timeprecision 1ps;
  int run = 0;
  logic last = 1'b0;
  initial begin
    hi_len = 0;
    lo_len = 0;
    falls = 0;
  end
  always @(posedge ref_clk) begin
    if (pin !== last) begin
      if (last) begin
        hi_len <= run;
        falls <= falls + 1;
      end else begin
        lo_len <= run;
      end
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last <= pin;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the reference clock output block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, srst, sleep, avs_read, avs_write, avs_waitrequest, ref_clock_out_pin;
  logic [10:0] src_levels;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  int hi_len, lo_len, falls, mismatches, compares, cycles;
  int ph[11];
  rcout_top i_rcout_top (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .sleep(sleep),
    .src_levels(src_levels), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ref_clock_out_pin(ref_clock_out_pin));
  rcout_clk_sink i_rcout_clk_sink (.ref_clk(ref_clk), .pin(ref_clock_out_pin),
    .hi_len(hi_len), .lo_len(lo_len), .falls(falls));
  // ******
  // clock, base clocks and watchdog
  // ******
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end
  // base clock i toggles every i+2 cycles, slow enough for edge sampling
  always @(posedge ref_clk) begin
    for (int i = 0; i < 11; i++) begin
      if (ph[i] == i + 1) begin
        ph[i] <= 0;
        src_levels[i] <= !src_levels[i];
      end else begin
        ph[i] <= ph[i] + 1;
      end
    end
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  // ******
  // helpers
  // ******
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s %0h not %0h", $time, what, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_falls(input int n);
    int f0;
    f0 = falls;
    for (int k = 0; k < 3000 && falls < f0 + n; k++) @(posedge ref_clk);
    if (falls < f0 + n) begin
      $display("wrong value at %0t: output stopped toggling", $time);
      mismatches++;
      results();
    end
  endtask
  task automatic setup(input logic [3:0] s, input logic [2:0] d, input logic [1:0] c);
    bus(1'b1, rcout_pkg::OFS_CONTROL, {3'h0, c, d}, 4'h1);
    bus(1'b1, rcout_pkg::OFS_SOURCE, {4'h0, s}, 4'h1);
    bus(1'b1, rcout_pkg::OFS_CONTROL, {3'h4, c, d}, 4'h1);
  endtask
  task automatic run_case(input logic [3:0] s, input logic [2:0] d, input logic [1:0] c,
                          input int hi, input int lo);
    setup(s, d, c);
    wait_falls(1);
    chk(hi_len, hi, "first high");
    wait_falls(1);
    chk(hi_len, hi, "high time");
    chk(lo_len, lo, "low time");
  endtask
  task automatic no_clock(input logic [3:0] s, input logic [2:0] d, input logic [1:0] c);
    int f0;
    setup(s, d, c);
    f0 = falls;
    repeat (300) @(posedge ref_clk);
    chk(falls, f0, "pulses seen");
    chk(ref_clock_out_pin, 0, "pin level");
  endtask
  // ******
  // scenarios
  // ******
  task automatic test_regs;
    bus(1'b0, rcout_pkg::OFS_CONTROL, 8'h00, 4'h1);
    chk(q, 32'h10, "control reset");
    bus(1'b0, rcout_pkg::OFS_SOURCE, 8'h00, 4'h1);
    chk(q, 32'h0, "source reset");
    bus(1'b1, rcout_pkg::OFS_CONTROL, 8'h7f, 4'h1);
    bus(1'b1, rcout_pkg::OFS_CONTROL, 8'h00, 4'h0);
    bus(1'b0, rcout_pkg::OFS_CONTROL, 8'h00, 4'h1);
    chk(q, 32'h1f, "control rw");
    bus(1'b1, rcout_pkg::OFS_SOURCE, 8'hff, 4'h1);
    bus(1'b0, rcout_pkg::OFS_SOURCE, 8'h00, 4'h1);
    chk(q, 32'h0f, "source rw");
    bus(1'b1, 4'hc, 8'hff, 4'h1);
    bus(1'b0, 4'hc, 8'h00, 4'h1);
    chk(q, 32'h0, "unmapped");
    $display("test registers done");
  endtask
  task automatic test_sources;
    // undivided, duty code has no effect and each base clock passes as is
    for (int i = 0; i < 11; i++) run_case(4'(i), 3'h0, 2'h1, i + 2, i + 2);
    no_clock(4'hb, 3'h0, 2'h2);
    $display("test sources done");
  endtask
  task automatic test_divide;
    run_case(4'h2, 3'h1, 2'h2, 8, 8);
    run_case(4'h2, 3'h2, 2'h1, 8, 24);
    run_case(4'h2, 3'h3, 2'h3, 48, 16);
    run_case(4'h2, 3'h7, 2'h2, 512, 512);
    no_clock(4'h2, 3'h2, 2'h0);
    $display("test divide done");
  endtask
  task automatic test_sleep;
    logic [31:0] lvl;
    run_case(4'h2, 3'h3, 2'h2, 32, 32);
    repeat (10) @(posedge ref_clk);
    sleep <= 1'b1;
    @(posedge ref_clk);
    lvl = {31'h0, ref_clock_out_pin};
    repeat (40) @(posedge ref_clk);
    chk(ref_clock_out_pin, lvl, "sleep level");
    bus(1'b0, rcout_pkg::OFS_STATUS, 8'h00, 4'h1);
    chk(q, {29'h0, lvl[0], 2'h2}, "status in sleep");
    bus(1'b1, rcout_pkg::OFS_CONTROL, 8'h10, 4'h1);
    chk(ref_clock_out_pin, 0, "stop in sleep");
    bus(1'b0, rcout_pkg::OFS_STATUS, 8'h00, 4'h1);
    chk(q, 32'h0, "status off");
    sleep <= 1'b0;
    $display("test sleep done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    sleep = 1'b0;
    src_levels = 11'h000;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    test_regs();
    test_sources();
    test_divide();
    test_sleep();
    results();
  end
endmodule
